//--- hdl/mmu_fault_walk.sv
// Memory fault log, identity/arbitration register, passthru and table walker.
// Assumes one clock, synchronous inputs, and a memory port that answers walk reads.
`timescale 1ns/1ps
`include "mmu_fault_defs.svh"
module mmu_fault_walk #(
    parameter logic [3:0] ID_VALUE = 4'h5, // Arbitrary identity value
    parameter logic [30:0] MEM_LIMIT = 31'h0800_0000
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire mmu_fault_pkg::cs_req_s csReq,
    output logic [31:0] csRdata,
    output logic csRvalid,
    input wire mmu_fault_pkg::mem_rec_s memRec,
    input wire logic bootModeFlag,
    output logic [4:0] busArbitrationEnables,
    input wire logic [3:0] slotPassthruEnable,
    input wire logic [3:0] segmentHighBit,
    input wire mmu_fault_pkg::io_req_s ioReq,
    output logic passthruHit,
    output logic passthruError,
    input wire logic cpuMiss,
    input wire logic [31:0] cpuVa,
    input wire logic [30:0] contextTableBase,
    input wire logic [7:0] contextNumberRegister,
    input wire logic [30:0] ioTableBase,
    output logic walkRdReq,
    output logic [30:0] walkRdAddr,
    output logic walkNoAllocate,
    input wire logic walkRdAck,
    input wire logic [31:0] walkRdData,
    output logic walkDone,
    output logic walkFault,
    output logic [31:0] pageEntry,
    output logic [30:0] mmuPhysicalAddress,
    output logic physValid
);
    import mmu_fault_pkg::*;

    function automatic logic [30:0] tableBaseOf(input logic [31:0] ptr);
        tableBaseOf = {ptr[26:2], 6'h00};
    endfunction : tableBaseOf

    function automatic logic [30:0] levelIndex(input logic [1:0] lvl,
                                               input logic [31:0] va);
        case (lvl)
            2'h1: levelIndex = {21'h0, va[31:24], 2'h0};
            2'h2: levelIndex = {23'h0, va[23:18], 2'h0};
            default: levelIndex = {23'h0, va[17:12], 2'h0};
        endcase
    endfunction : levelIndex

    // Fault log state
    logic [31:0] statusReg, statusNext;
    logic [30:0] faultAddrReg, faultAddrNext;
    logic lockReg, lockNext;
    logic [4:0] arbReg, arbNext;
    wire csRd = csReq.valid & ~csReq.write;
    wire csWr = csReq.valid & csReq.write;
    wire selFsr = csReq.addr == `FSR_ADDR;
    wire selFar = csReq.addr == `FAR_ADDR;
    wire selIdr = csReq.addr == `IDR_ADDR;
    wire statusRead = csRd & selFsr;
    // [R2] read unlocks
    // Record and read in one cycle: the record is taken
    wire effLocked = lockReg & ~statusRead;
    wire recErr = memRec.valid & (|memRec.parityErr);
    wire [31:0] capStatus;

    // [R4] summary bit
    assign capStatus[`FSR_ERR] = |memRec.parityErr;
    assign capStatus[30:25] = 6'h00;
    // [R6] mode and origin
    assign capStatus[`FSR_SUP] = memRec.supervisor;
    assign capStatus[`FSR_CPU] = memRec.cpuInit;
    assign capStatus[22:20] = 3'h0;
    assign capStatus[`FSR_MULTI] = 1'b0;
    assign capStatus[18:15] = 4'h0;
    // [R5] parity pair
    assign capStatus[`FSR_PE0] = memRec.parityErr[1];
    assign capStatus[`FSR_PE1] = memRec.parityErr[0];
    // [R7] boot mode
    assign capStatus[`FSR_BOOT] = bootModeFlag;
    // [R8] cacheable only for processor requests
    assign capStatus[`FSR_C] = memRec.cpuInit & memRec.cacheable;
    assign capStatus[10:8] = 3'h0;
    // [R9] request type code
    assign capStatus[`FSR_TYPE_LO+3:`FSR_TYPE_LO] = memRec.reqType;
    // [R10] unused bits zero
    assign capStatus[3:0] = 4'h0;

    always_comb
    begin
        statusNext = statusReg;
        faultAddrNext = faultAddrReg;
        lockNext = effLocked;
        // [R1] load while unlocked
        // [R12] address held only while locked
        if (memRec.valid && !effLocked)
        begin
            statusNext = capStatus;
            // [R11] address capture
            faultAddrNext = memRec.addr;
            // [R23] lock together
            lockNext = recErr;
        end
        // [R3] keep first, flag more
        else if (recErr && effLocked)
        begin
            statusNext[`FSR_MULTI] = 1'b1;
        end
    end

    // [R14] writable enables, [R13] identity ignores writes
    assign arbNext = (csWr & selIdr) ? csReq.wdata[`IDR_ARB_LO+4:`IDR_ARB_LO] : arbReg;
    assign busArbitrationEnables = arbReg;

    wire [31:0] idrValue = {11'h000, arbReg, 12'h000, ID_VALUE};
    // [R11] bit 31 reads zero
    wire [31:0] rdMux = selFsr ? statusReg :
                        selFar ? {1'b0, faultAddrReg} :
                        selIdr ? idrValue : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            statusReg <= 32'h0000_0000;
            faultAddrReg <= 31'h0000_0000;
            lockReg <= 1'b0;
            arbReg <= `ARB_RESET;
            csRdata <= 32'h0000_0000;
            csRvalid <= 1'b0;
        end
        else if (clkEn)
        begin
            statusReg <= statusNext;
            faultAddrReg <= faultAddrNext;
            lockReg <= lockNext;
            arbReg <= arbNext;
            csRdata <= csRd ? rdMux : csRdata;
            csRvalid <= csRd;
        end
    end

    // Passthru path
    wire slotBypass = slotPassthruEnable[ioReq.slot];
    // [R15] top bits zero select passthru
    wire ioPass = ioReq.valid & slotBypass & (ioReq.ioVirtualAddress[31:30] == 2'h0);
    // [R22] segment bit supplies bit 30
    wire [30:0] passAddr = {segmentHighBit[ioReq.slot], ioReq.ioVirtualAddress[29:0]};
    // [R16] range check
    wire passBad = passAddr >= MEM_LIMIT;
    wire ioWalkStart = ioReq.valid & ~ioPass;

    // Table walker
    walk_state_e stateReg, stateNext;
    logic [1:0] levelReg, levelNext;
    logic ioWalkReg, ioWalkNext;
    logic [31:0] vaReg, vaNext;
    logic [30:0] addrReg, addrNext;
    logic [31:0] pteReg, pteNext;
    logic [30:0] parReg, parNext;
    logic parValidReg, parValidNext;
    logic passHitReg, passErrReg;
    wire [1:0] entryType = walkRdData[1:0];
    wire [30:0] pagePa = {walkRdData[26:8], 12'h000};
    // IO tables map small pages only, so an IO entry keeps the low offset
    wire [30:0] offMask = ioWalkReg ? 31'h0000_0fff :
                          (levelReg == 2'h1) ? 31'h00ff_ffff :
                          (levelReg == 2'h2) ? 31'h0003_ffff : 31'h0000_0fff;
    wire [30:0] transPa = (pagePa & ~offMask) | (vaReg[30:0] & offMask);

    always_comb
    begin
        stateNext = stateReg;
        levelNext = levelReg;
        ioWalkNext = ioWalkReg;
        vaNext = vaReg;
        addrNext = addrReg;
        pteNext = pteReg;
        parNext = parReg;
        parValidNext = 1'b0;
        // [R17] passthru result held internally
        if (ioPass && !passBad)
        begin
            parNext = passAddr;
            parValidNext = 1'b1;
        end
        case (stateReg)
            W_IDLE:
            begin
                if (ioWalkStart)
                begin
                    // [R20] single first-level table
                    stateNext = W_FETCH;
                    ioWalkNext = 1'b1;
                    levelNext = 2'h1;
                    vaNext = ioReq.ioVirtualAddress;
                    addrNext = ioTableBase + {11'h000, ioReq.ioVirtualAddress[29:12], 2'h0};
                end
                else if (cpuMiss)
                begin
                    // [R18] context table entry
                    stateNext = W_CTX;
                    ioWalkNext = 1'b0;
                    levelNext = 2'h0;
                    vaNext = cpuVa;
                    addrNext = contextTableBase + {21'h0, contextNumberRegister, 2'h0};
                end
            end
            W_CTX:
            begin
                if (walkRdAck)
                begin
                    // [R18] context entry acts as pointer
                    if (entryType == `ET_POINTER)
                    begin
                        stateNext = W_FETCH;
                        levelNext = 2'h1;
                        addrNext = tableBaseOf(walkRdData) | levelIndex(2'h1, vaReg);
                    end
                    else
                    begin
                        stateNext = W_FAULT;
                    end
                end
            end
            W_FETCH:
            begin
                if (walkRdAck)
                begin
                    // [R19] follow pointers, stop on entry
                    if (entryType == `ET_ENTRY)
                    begin
                        stateNext = W_DONE;
                        pteNext = walkRdData;
                        parNext = transPa;
                        parValidNext = 1'b1;
                    end
                    else if (entryType == `ET_POINTER && !ioWalkReg &&
                             levelReg != `LAST_LEVEL)
                    begin
                        levelNext = levelReg + 2'h1;
                        addrNext = tableBaseOf(walkRdData) |
                                   levelIndex(levelReg + 2'h1, vaReg);
                    end
                    else
                    begin
                        stateNext = W_FAULT;
                    end
                end
            end
            W_DONE: stateNext = W_IDLE;
            W_FAULT: stateNext = W_IDLE;
            default: stateNext = W_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stateReg <= W_IDLE;
            levelReg <= 2'h0;
            ioWalkReg <= 1'b0;
            vaReg <= 32'h0000_0000;
            addrReg <= 31'h0000_0000;
            pteReg <= 32'h0000_0000;
            parReg <= 31'h0000_0000;
            parValidReg <= 1'b0;
            passHitReg <= 1'b0;
            passErrReg <= 1'b0;
        end
        else if (clkEn)
        begin
            stateReg <= stateNext;
            levelReg <= levelNext;
            ioWalkReg <= ioWalkNext;
            vaReg <= vaNext;
            addrReg <= addrNext;
            pteReg <= pteNext;
            parReg <= parNext;
            parValidReg <= parValidNext;
            passHitReg <= ioPass;
            passErrReg <= ioPass & passBad;
        end
    end

    // Read request stands until the memory acknowledges
    assign walkRdReq = (stateReg == W_CTX) || (stateReg == W_FETCH);
    assign walkRdAddr = addrReg;
    // [R21] walk fetches bypass the cache
    assign walkNoAllocate = walkRdReq;
    assign walkDone = stateReg == W_DONE;
    assign walkFault = stateReg == W_FAULT;
    assign pageEntry = pteReg;
    assign mmuPhysicalAddress = parReg;
    assign physValid = parValidReg;
    assign passthruHit = passHitReg;
    assign passthruError = passErrReg;

    // Checks
    chk_lock_on_error: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R23]
        clkEn && memRec.valid && !effLocked && recErr |=> lockReg &&
        faultAddrReg == $past(memRec.addr))
        else $error("error did not lock status and address together");
    chk_hold_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R3]
        clkEn && lockReg && !statusRead && recErr |=> statusReg[`FSR_MULTI] &&
        statusReg[30:20] == $past(statusReg[30:20]))
        else $error("second error disturbed held status");
    chk_read_unlocks: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R2]
        clkEn && statusRead && !recErr |=> !lockReg)
        else $error("status read did not unlock");
    chk_summary_bit: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R4]
        statusReg[`FSR_ERR] == (statusReg[`FSR_PE0] | statusReg[`FSR_PE1]))
        else $error("summary bit mismatch");
    chk_addr_follows: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R12]
        clkEn && memRec.valid && !lockReg |=> faultAddrReg == $past(memRec.addr))
        else $error("unlocked address did not load");
    chk_cache_flag: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
        !statusReg[`FSR_CPU] |-> !statusReg[`FSR_C])
        else $error("cacheable set for io request");
    chk_ident_const: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R13]
        csRvalid && $past(selIdr) |-> csRdata[3:0] == ID_VALUE)
        else $error("identity field changed");
    chk_pass_addr: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R22]
        clkEn && ioPass && !passBad |=> parReg[29:0] ==
        $past(ioReq.ioVirtualAddress[29:0]) && physValid)
        else $error("passthru address not forwarded");
    chk_pass_range: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R16]
        clkEn && ioPass && passBad |=> passthruError && !physValid)
        else $error("out of range passthru not refused");
    chk_io_one_level: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R20]
        ioWalkReg && stateReg == W_FETCH |-> levelReg == 2'h1)
        else $error("io walk went deeper");
    chk_walk_depth: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R19]
        clkEn && stateReg == W_FETCH && walkRdAck && levelReg == `LAST_LEVEL &&
        entryType != `ET_ENTRY |=> walkFault)
        else $error("third level pointer not faulted");
endmodule : mmu_fault_walk

//--- hdl/mmu_fault_defs.svh
// Offsets, field positions, reset values and codes for the fault log and walker.
// Assumes inclusion by the design file and the bench.
//
// Overview of operation
// [R1] Fault status captures every memory request record while unlocked.
// [R2] A captured error freezes status until read; the read unlocks.
// [R3] Later errors keep the first status and set the multi-error bit 19.
// [R4] Bit 31 reads as the OR of both parity flags.
// [R5] Bits 14 and 13 flag parity faults on even and odd words.
// [R6] Bit 24 keeps supervisor mode; bit 23 keeps processor-initiated.
// [R7] Bit 12 keeps the boot mode flag of the processor control register.
// [R8] Bit 11 copies page cacheable flag for processor requests, else zero.
// [R9] Bits 7:4 hold the request type code; other codes are reserved.
// [R10] Unimplemented status bits read as zero.
// [R11] Fault address captures the 31-bit address; bit 31 reads zero.
// [R12] Fault address holds only while an error is held in status.
// [R13] Identity bits 3:0 return a constant; writes are ignored.
// [R14] Bits 20:16 enable arbitration: top bit network master, rest slots.
// [R15] A passthru master issues top bits zero; the address passes through.
// [R16] Passthru addresses outside main memory return an error to the master.
// [R17] An internal 31-bit register holds each translated address, no software path; a walk entry in the same cycle overwrites a passthru address.
// [R18] Processor walk starts at context base indexed by context, up to 3 levels.
// [R19] Walk follows pointers to an entry; faults on invalid, reserved, or level 3 pointer.
// [R20] IO walks read only one first-level table.
// [R21] Walk fetches are never allocated into the data cache.
// [R22] Passthru address bit 30 comes from the segment bit; bits 29:0 pass.
// [R23] Status and address lock together on the first error.
`ifndef MMU_FAULT_DEFS_SVH
`define MMU_FAULT_DEFS_SVH
`define FSR_ADDR 32'h1000_1020
`define FAR_ADDR 32'h1000_1024
`define IDR_ADDR 32'h1000_2000
`define FSR_ERR 31
`define FSR_SUP 24
`define FSR_CPU 23
`define FSR_MULTI 19
`define FSR_PE0 14
`define FSR_PE1 13
`define FSR_BOOT 12
`define FSR_C 11
`define FSR_TYPE_LO 4
`define IDR_ARB_LO 16
`define ARB_RESET 5'h00
`define ET_INVALID 2'h0
`define ET_POINTER 2'h1
`define ET_ENTRY 2'h2
`define LAST_LEVEL 2'h3
`endif

//--- hdl/mmu_fault_pkg.sv
// Types shared by the fault log and table walker.
// Assumes the constants header sits beside it.
package mmu_fault_pkg;
    // Completed memory request as seen by the fault log
    typedef struct packed {
        logic valid;
        logic [30:0] addr;
        logic [3:0] reqType;
        logic cpuInit;
        logic supervisor;
        logic cacheable;
        logic [1:0] parityErr;
    } mem_rec_s;
    // Control space access
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } cs_req_s;
    // IO translation request
    typedef struct packed {
        logic valid;
        logic [1:0] slot;
        logic [31:0] ioVirtualAddress;
    } io_req_s;
    typedef enum logic [2:0] {
        W_IDLE = 3'h0,
        W_CTX = 3'h1,
        W_FETCH = 3'h3,
        W_DONE = 3'h2,
        W_FAULT = 3'h6
    } walk_state_e;
endpackage : mmu_fault_pkg

//--- verification/walk_mem_model.sv
// Behavioural main memory that answers the walker's table reads.
// Assumes the bench fills mem before each walk; unknown addresses read as zero.
`timescale 1ns/1ps
module walk_mem_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic walkRdReq,
    input wire logic [30:0] walkRdAddr,
    output logic walkRdAck,
    output logic [31:0] walkRdData
);
    logic [31:0] mem [logic [30:0]];
    int waitCnt = 0;
    int pace = 0;
    initial
    begin
        walkRdAck = 1'b0;
        walkRdData = 32'h5a5a_a5a5;
        forever
        begin
            @(posedge ref_clk);
            #1;
            // Data is not held outside the ack cycle
            if (walkRdAck || !rst_b || !walkRdReq || waitCnt > 0)
            begin
                if (waitCnt > 0 && walkRdReq && !walkRdAck)
                    waitCnt--;
                walkRdAck = 1'b0;
                walkRdData = ~walkRdData;
            end
            else
            begin
                walkRdAck = 1'b1;
                walkRdData = mem.exists(walkRdAddr) ? mem[walkRdAddr] : 32'h0;
                // Cycle the answer delay through 0, 1, 2 and 3 wait cycles
                waitCnt = pace;
                pace = (pace + 1) % 4;
            end
        end
    end
endmodule : walk_mem_model

//--- verification/mmu_fault_walk_tb_top.sv
// Self-checking bench for the fault log, identity register, passthru and walker.
// Assumes walk_mem_model stands in for main memory on the walk read port.
`timescale 1ns/1ps
`include "mmu_fault_defs.svh"
module mmu_fault_walk_tb_top;
    import mmu_fault_pkg::*;
    logic ref_clk = 0, rst_b = 0, clkEn = 1, bootModeFlag = 0, cpuMiss = 0;
    cs_req_s csReq = '0;
    mem_rec_s memRec = '0;
    io_req_s ioReq = '0;
    logic [3:0] slotPassthruEnable = 4'h5, segmentHighBit = 4'h4;
    logic [31:0] cpuVa = 32'h0;
    logic [30:0] contextTableBase = 31'h0010_0000, ioTableBase = 31'h0050_0000;
    logic [7:0] contextNumberRegister = 8'h03;
    logic [31:0] csRdata, walkRdData, pageEntry;
    logic csRvalid, passthruHit, passthruError, walkRdReq, walkNoAllocate, walkRdAck;
    logic walkDone, walkFault, physValid;
    logic [4:0] busArbitrationEnables;
    logic [30:0] walkRdAddr, mmuPhysicalAddress;
    int numErrors = 0, cmpCount = 0, cycles = 0, seed = 32'hc7e7;
    logic [31:0] rdQ[$];
    logic [32:0] paQ[$];
    logic [30:0] addrQ[$];
    logic [33:0] doneQ[$];
    logic [32:0] e;
    logic [33:0] d;
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h9, 4'ha, 4'hb, 4'hc};
    mem_rec_s r1, r2;
    logic bm;

    always #25 ref_clk = ~ref_clk;

    mmu_fault_walk #(.ID_VALUE(4'h5), .MEM_LIMIT(31'h0800_0000)) mmu_fault_walk_inst (
        .ref_clk, .rst_b, .clkEn, .csReq, .csRdata, .csRvalid, .memRec, .bootModeFlag,
        .busArbitrationEnables, .slotPassthruEnable, .segmentHighBit, .ioReq, .passthruHit,
        .passthruError, .cpuMiss, .cpuVa, .contextTableBase, .contextNumberRegister,
        .ioTableBase, .walkRdReq, .walkRdAddr, .walkNoAllocate, .walkRdAck, .walkRdData,
        .walkDone, .walkFault, .pageEntry, .mmuPhysicalAddress, .physValid);
    walk_mem_model walk_mem_model_inst (
        .ref_clk, .rst_b, .walkRdReq, .walkRdAddr, .walkRdAck, .walkRdData);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic endSim;
        if (numErrors == 0 && cmpCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : endSim

    // Result monitor: each result takes the oldest expectation of its kind
    always @(posedge ref_clk)
    begin
        if (csRvalid === 1'b1)
            check("read data", csRdata, rdQ.size() ? rdQ.pop_front() : 'x);
        if (physValid === 1'b1 || passthruError === 1'b1)
        begin
            e = paQ.size() ? paQ.pop_front() : 'x;
            check("pa flags", {passthruError, physValid}, e[31] ? 2'b10 : 2'b01);
            if (!e[31])
            begin
                check("passthru hit", passthruHit, e[32]);
                check("phys address", mmuPhysicalAddress, e[30:0]);
            end
        end
        if (walkRdReq === 1'b1 && walkRdAck === 1'b1)
        begin
            check("walk address", walkRdAddr, addrQ.size() ? addrQ.pop_front() : 'x);
            check("no allocate", walkNoAllocate, 1'b1);
        end
        if (walkDone === 1'b1 || walkFault === 1'b1)
        begin
            d = doneQ.size() ? doneQ.pop_front() : 'x;
            check("walk end", {walkDone, walkFault}, d[33:32]);
            if (d[33])
                check("page entry", pageEntry, d[31:0]);
        end
        cycles++;
        if (cycles > 20000)
        begin
            numErrors++;
            endSim();
        end
    end

    task automatic csAccess(input logic wr, input logic [31:0] a, input logic [31:0] wd,
            input logic [31:0] exp);
        @(negedge ref_clk);
        if (!wr)
            rdQ.push_back(exp);
        csReq <= '{1'b1, wr, a, wd};
        @(negedge ref_clk);
        csReq <= '0;
    endtask : csAccess

    task automatic sendRec(input mem_rec_s r, input logic b);
        @(negedge ref_clk);
        memRec <= r;
        bootModeFlag <= b;
        @(negedge ref_clk);
        memRec <= '0;
    endtask : sendRec

    function automatic mem_rec_s randRec(input logic [3:0] t, input logic [1:0] pe);
        return mem_rec_s'({1'b1, 31'($random(seed)), t, 3'($random(seed)), pe});
    endfunction : randRec

    function automatic logic [31:0] fsr(input mem_rec_s r, input logic b, input logic me);
        return {|r.parityErr, 6'h0, r.supervisor, r.cpuInit, 3'h0, me, 4'h0, r.parityErr, b,
            r.cpuInit & r.cacheable, 3'h0, r.reqType, 4'h0};
    endfunction : fsr

    task automatic ioSend(input logic [1:0] slot, input logic [31:0] va);
        int n;
        @(negedge ref_clk);
        ioReq <= '{1'b1, slot, va};
        @(negedge ref_clk);
        ioReq <= '0;
        for (n = 0; n < 200 && (doneQ.size() || paQ.size()); n++)
            @(negedge ref_clk);
        repeat (2) @(negedge ref_clk);
    endtask : ioSend

    task automatic cpuWalk(input logic [31:0] va, input int last, input logic [1:0] et);
        logic [30:0] a [4];
        logic [30:0] b [4];
        logic [31:0] w;
        int i;
        b = '{31'h0, 31'h0020_0000, 31'h0030_0000, 31'h0040_0000};
        a[0] = contextTableBase + {contextNumberRegister, 2'b00};
        a[1] = b[1] + {va[31:24], 2'b00};
        a[2] = b[2] + {va[23:18], 2'b00};
        a[3] = b[3] + {va[17:12], 2'b00};
        for (i = 0; i <= last; i++)
        begin
            w = (i < last) ? {5'h0, b[i + 1][30:6], 2'b01} : {5'h0, 19'($random(seed)), 6'h0, et};
            walk_mem_model_inst.mem[a[i]] = w;
            addrQ.push_back(a[i]);
        end
        if (et == `ET_ENTRY)
        begin
            doneQ.push_back({2'b10, w});
            paQ.push_back({2'b00, w[26:8], va[11:0]});
        end
        else
            doneQ.push_back({2'b01, 32'h0});
        @(negedge ref_clk);
        cpuVa <= va;
        cpuMiss <= 1'b1;
        @(negedge ref_clk);
        cpuMiss <= 1'b0;
        ioSend(2'h0, 32'hc000_0000);
    endtask : cpuWalk

    initial
    begin
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        csAccess(1'b0, `FSR_ADDR, 0, 32'h0);
        csAccess(1'b0, `IDR_ADDR, 0, 32'h0000_0005);
        csAccess(1'b1, `IDR_ADDR, 32'hffff_ffff, 0);
        csAccess(1'b0, `IDR_ADDR, 0, 32'h001f_0005);
        csAccess(1'b1, `IDR_ADDR, 32'h0015_000a, 0);
        csAccess(1'b0, `IDR_ADDR, 0, 32'h0015_0005);
        check("enables", busArbitrationEnables, 5'h15);
        csAccess(1'b0, 32'h1000_1028, 0, 32'h0);
        foreach (codes[i])
        begin
            r1 = randRec(codes[i], 2'b00);
            bm = 1'($random(seed));
            sendRec(r1, bm);
            csAccess(1'b0, `FSR_ADDR, 0, fsr(r1, bm, 1'b0));
            csAccess(1'b0, `FAR_ADDR, 0, {1'b0, r1.addr});
        end
        // a record under a low clock enable is not taken
        @(negedge ref_clk);
        clkEn <= 1'b0;
        sendRec(randRec(4'h4, 2'b11), 1'b0);
        clkEn <= 1'b1;
        csAccess(1'b0, `FSR_ADDR, 0, fsr(r1, bm, 1'b0));
        r1 = randRec(4'h9, 2'b01);
        r1.cpuInit = 1'b1;
        r1.cacheable = 1'b1;
        sendRec(r1, 1'b1);
        sendRec(randRec(4'h1, 2'b10), 1'b0);
        sendRec(randRec(4'h2, 2'b00), 1'b0);
        csAccess(1'b0, `FAR_ADDR, 0, {1'b0, r1.addr});
        csAccess(1'b0, `FSR_ADDR, 0, fsr(r1, 1'b1, 1'b1));
        r2 = randRec(4'hb, 2'b11);
        sendRec(r2, 1'b0);
        csAccess(1'b0, `FAR_ADDR, 0, {1'b0, r2.addr});
        csAccess(1'b0, `FSR_ADDR, 0, fsr(r2, 1'b0, 1'b0));
        // passthru with top bits zero, and range edge
        e = {2'b10, 1'b0, 30'($random(seed)) & 30'h07ff_fffc};
        paQ.push_back(e);
        ioSend(2'h0, {2'b00, e[29:0]});
        paQ.push_back({2'b10, 31'h07ff_fffc});
        ioSend(2'h0, 32'h07ff_fffc);
        paQ.push_back({2'b01, 31'h0});
        ioSend(2'h0, 32'h0800_0000);
        paQ.push_back({2'b01, 31'h0});
        ioSend(2'h2, 32'h0000_1000);
        // walks ending in entry, invalid, reserved, level-3 pointer
        cpuWalk(32'($random(seed)), 3, `ET_ENTRY);
        cpuWalk(32'($random(seed)), 1, `ET_INVALID);
        cpuWalk(32'($random(seed)), 2, 2'h3);
        cpuWalk(32'($random(seed)), 3, `ET_POINTER);
        cpuVa = 32'($random(seed));
        walk_mem_model_inst.mem[ioTableBase + {cpuVa[29:12], 2'b00}] = 32'h0123_4502;
        addrQ.push_back(ioTableBase + {cpuVa[29:12], 2'b00});
        doneQ.push_back({2'b10, 32'h0123_4502});
        paQ.push_back({2'b00, 19'h1_2345, cpuVa[11:0]});
        ioSend(2'h1, cpuVa);
        repeat (5) @(negedge ref_clk);
        check("pending", rdQ.size() + paQ.size() + addrQ.size() + doneQ.size(), 0);
        endSim();
    end
endmodule : mmu_fault_walk_tb_top
